// >>> hw/tpg_pkg.sv
// Purpose: shared constants and carrier types of the ten-bit pwm generator
// Assumes: 8-bit register port, one 100 MHz clock
// Notes: offsets are register indexes on the plain register port
package tpg_pkg;
    localparam int CHAN_N = 2;
    localparam int TMR_N = 3;
    localparam int DUTY_W = 10;
    localparam int ADDR_W = 5;
    localparam int CLK_PERIOD_NS = 10;

    // register map
    localparam int OFS_CH_BASE = 'h00;
    localparam int OFS_CH_STRIDE = 'h03;
    localparam int OFS_CTRL = 'h0;
    localparam int OFS_DHI = 'h1;
    localparam int OFS_DLO = 'h2;
    localparam logic [4:0] OFS_TSEL = 5'h06;
    localparam logic [4:0] OFS_DIR = 5'h07;
    localparam int OFS_TMR_BASE = 'h08;
    localparam int OFS_TMR_STRIDE = 'h04;
    localparam int OFS_TCNT = 'h0;
    localparam int OFS_TPER = 'h1;
    localparam int OFS_TCON = 'h2;

    // field positions
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_POL_BIT = 4;
    localparam int DLO_LSB = 6;
    localparam int TCON_ON_BIT = 7;
    localparam int TCON_PS_LSB = 0;
    localparam int TSEL_CH_LSB = 4;

    // reset values
    localparam logic [7:0] TSEL_RST = 8'h55;
    localparam logic [7:0] TPER_RST = 8'hFF;
    localparam logic [7:0] DHI_RST = 8'h00;
    localparam logic [1:0] DLO_RST = 2'h0;
    localparam logic [1:0] TCON_PS_RST = 2'h0;

    // timer select codes
    localparam logic [1:0] TSEL_SECOND = 2'h2;
    localparam logic [1:0] TSEL_THIRD = 2'h3;

    // system clocks per timer step minus one, indexed by prescale code 1:1, 1:4, 1:16, 1:64
    localparam logic [7:0] SC_LIMIT [4] = '{8'h03, 8'h0F, 8'h3F, 8'hFF};

    typedef struct packed {
        logic wrap;
        logic [DUTY_W-1:0] tbase;
    } tpg_tick_type;

    typedef struct packed {
        logic en;
        logic polarity_select_bit;
        logic [DUTY_W-1:0] duty;
    } tpg_chcfg_type;
endpackage

// >>> hw/tpg_timer.sv
// Purpose: 8-bit period timer fed by the quarter-rate instruction clock
// Assumes: i_run is low while the timer is off or the device sleeps
// Notes: the prescaler counter doubles as the low two bits of the time base
module tpg_timer (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_run,
    input wire logic [7:0] i_period,
    input wire logic [1:0] i_prescale,
    output tpg_pkg::tpg_tick_type o_tick,
    output logic [7:0] o_count
);
    logic [7:0] count_q;
    logic [7:0] sc_q;
    logic last;
    logic at_period;

    assign last = (sc_q == tpg_pkg::SC_LIMIT[i_prescale]);
    assign at_period = (count_q == i_period);
    assign o_count = count_q;

    // the step enable is sc_q wrapping: four system clocks times the prescale
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sc_q <= 8'h00;
            count_q <= 8'h00;
        end else if (i_run) begin
            if (last) begin
                sc_q <= 8'h00;
                count_q <= at_period ? 8'h00 : 8'(count_q + 8'h01);
            end else begin
                sc_q <= 8'(sc_q + 8'h01);
            end
        end
    end

    always_comb begin
        o_tick.wrap = i_run && last && at_period;
        unique case (i_prescale)
            2'h0: o_tick.tbase = {count_q, sc_q[1:0]};
            2'h1: o_tick.tbase = {count_q, sc_q[3:2]};
            2'h2: o_tick.tbase = {count_q, sc_q[5:4]};
            2'h3: o_tick.tbase = {count_q, sc_q[7:6]};
        endcase
    end

    a_wrap_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_tick.wrap |=> count_q == 8'h00)
        else $error("timer not cleared after period match");
    a_count_steps: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_run && last && !at_period |=> count_q == 8'($past(count_q) + 8'h01))
        else $error("timer did not step");
    a_sleep_holds: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_run |=> $stable(count_q) && $stable(sc_q))
        else $error("timer moved while stopped");
endmodule

// >>> hw/tpg_channel.sv
// Purpose: one modulator channel with double-buffered duty; polarity is applied unbuffered
// Assumes: tick comes from the timer chosen for this channel
// Notes: out level is registered together with the raw level, so the pin changes in the same clock as raw_q
module tpg_channel (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_run,
    input tpg_pkg::tpg_tick_type i_tick,
    input tpg_pkg::tpg_chcfg_type i_cfg,
    output logic o_out
);
    logic [tpg_pkg::DUTY_W-1:0] buf_q;
    logic raw_q;
    logic raw_d;
    logic out_q;
    logic wrap_q;

    assign o_out = out_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            buf_q <= '0;
        end else if (i_run && i_cfg.en && i_tick.wrap) begin
            buf_q <= i_cfg.duty;
        end
    end

    // set one clock after the wrap, once the timer reads zero, so the high time is exactly
    // duty steps; a duty beyond the last time base value is never matched, so the level stays set
    always_comb begin
        raw_d = raw_q;
        if (!i_cfg.en) begin
            raw_d = 1'b0;
        end else if (wrap_q) begin
            raw_d = (buf_q != '0);
        end else if (i_tick.tbase == buf_q) begin
            raw_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            raw_q <= 1'b0;
            out_q <= 1'b0;
            wrap_q <= 1'b0;
        end else if (i_run) begin
            wrap_q <= i_tick.wrap;
            raw_q <= raw_d;
            out_q <= raw_d ^ i_cfg.polarity_select_bit;
        end
    end

    sequence s_wrap_live;
        i_run && i_cfg.en && i_tick.wrap && i_cfg.duty != '0 ##1 i_run && i_cfg.en;
    endsequence
    sequence s_goes_active;
        raw_q && out_q == !$past(i_cfg.polarity_select_bit);
    endsequence

    a_wrap_sets: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_wrap_live |=> s_goes_active)
        else $error("output not set at period wrap");
    a_zero_duty: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_run && i_cfg.en && i_tick.wrap && i_cfg.duty == '0 ##1 i_run |=> !raw_q)
        else $error("zero duty set the output");
    a_match_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_run && i_cfg.en && !wrap_q && i_tick.tbase == buf_q |=> !raw_q)
        else $error("output not cleared at duty match");
    a_buf_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_run && i_cfg.en && i_tick.wrap |=> buf_q == $past(i_cfg.duty))
        else $error("duty buffer not loaded at wrap");
    a_buf_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_tick.wrap |=> $stable(buf_q))
        else $error("duty buffer changed between wraps");
    a_buf_frozen: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_cfg.en |=> $stable(buf_q))
        else $error("disabled channel loaded its duty buffer");
    a_idle_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_run && !i_cfg.en |=> out_q == $past(i_cfg.polarity_select_bit))
        else $error("disabled channel not inactive");
    a_sleep_level: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_run |=> $stable(out_q) && $stable(raw_q))
        else $error("output moved during sleep");
endmodule

// >>> hw/tpg_pwm_top.sv
// Purpose: two ten-bit pwm channels on three selectable 8-bit period timers
// Assumes: register port is synchronous to i_clk; i_sleep freezes the block
// Notes: registers are 8 bits wide; unmapped reads return zero
// Functional notes
// - each channel resolves duty to ten bits.
// - each channel picks its timer by its own select field, first timer at reset.
// - channels on one timer share its period, duty stays per channel.
// - no timer postscaler takes part in modulation.
// - all channels on a timer go active when that timer clears.
// - a channel goes inactive when the ten-bit time base equals its duty.
// - duty at or past the period never clears the output.
// - duty registers load into buffers at period match; software writes before it.
// - after period match: clear timer, latch duty, go active unless duty is zero.
// - polarity bit set inverts the output.
// - period is (period value plus one) times four oscillator clocks times prescale.
// - duty is high byte plus bits 7:6 of low register, writable anytime.
// - pulse width is duty times oscillator clock times prescale.
// - time base is timer count with two prescaler or clock bits below.
// - resolution is log2 of four times period plus one, ten bits at 255.
// - a pulse width longer than the period leaves the pin unchanged.
// - sleep stops timers, freezes state, holds output; wake resumes the count.
// - reset makes pins inputs and restores control and duty registers.
// - control register: enable bit 7, output level bit 5, polarity bit 4.
// - select 11 third timer, 10 second, 01 first, 00 reserved.
//
// Strobed register access and the placing of the registers were decided locally.
module tpg_pwm_top (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_sleep,
    input wire logic [tpg_pkg::ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic [tpg_pkg::CHAN_N-1:0] o_pwm,
    output logic [tpg_pkg::CHAN_N-1:0] o_pwm_oe
);
    localparam int NC = tpg_pkg::CHAN_N;
    localparam int NT = tpg_pkg::TMR_N;

    logic [7:0] tsel_q;
    logic [NC-1:0] oe_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic [NC-1:0] en_q;
    logic [NC-1:0] pol_q;
    logic [7:0] dhi_q [NC];
    logic [1:0] dlo_q [NC];
    logic [NC-1:0] out_lvl;

    logic [NT-1:0] ton_q;
    logic [7:0] tper_q [NT];
    logic [1:0] tps_q [NT];
    logic [7:0] tcnt [NT];
    tpg_pkg::tpg_tick_type tick [NT];

    logic [1:0] tidx [NC];
    tpg_pkg::tpg_tick_type ch_tick [NC];

    assign o_rdata = rdata_q;
    assign o_pwm = out_lvl;
    assign o_pwm_oe = oe_q;

    // shared registers: timer routing and pin direction
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tsel_q <= tpg_pkg::TSEL_RST;
        end else if (i_wr && i_addr == tpg_pkg::OFS_TSEL) begin
            tsel_q <= i_wdata;
        end
    end

    // oe high means the pin is driven; reset leaves every pin an input
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            oe_q <= '0;
        end else if (i_wr && i_addr == tpg_pkg::OFS_DIR) begin
            oe_q <= ~i_wdata[NC-1:0];
        end
    end

    // timers, one per generate entry; the postscaler is not modelled as it never
    // feeds the modulator
    for (genvar t = 0; t < NT; t++) begin : g_tmr
        localparam logic [4:0] A_TCNT = 5'(tpg_pkg::OFS_TMR_BASE + t * tpg_pkg::OFS_TMR_STRIDE + tpg_pkg::OFS_TCNT);
        localparam logic [4:0] A_TPER = 5'(tpg_pkg::OFS_TMR_BASE + t * tpg_pkg::OFS_TMR_STRIDE + tpg_pkg::OFS_TPER);
        localparam logic [4:0] A_TCON = 5'(tpg_pkg::OFS_TMR_BASE + t * tpg_pkg::OFS_TMR_STRIDE + tpg_pkg::OFS_TCON);

        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                tper_q[t] <= tpg_pkg::TPER_RST;
            end else if (i_wr && i_addr == A_TPER) begin
                tper_q[t] <= i_wdata;
            end
        end

        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                ton_q[t] <= 1'b0;
                tps_q[t] <= tpg_pkg::TCON_PS_RST;
            end else if (i_wr && i_addr == A_TCON) begin
                ton_q[t] <= i_wdata[tpg_pkg::TCON_ON_BIT];
                tps_q[t] <= i_wdata[tpg_pkg::TCON_PS_LSB +: 2];
            end
        end

        tpg_timer u_timer (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_run(ton_q[t] && !i_sleep),
            .i_period(tper_q[t]),
            .i_prescale(tps_q[t]),
            .o_tick(tick[t]),
            .o_count(tcnt[t])
        );
    end

    // channels
    for (genvar c = 0; c < NC; c++) begin : g_ch
        localparam logic [4:0] A_CTRL = 5'(tpg_pkg::OFS_CH_BASE + c * tpg_pkg::OFS_CH_STRIDE + tpg_pkg::OFS_CTRL);
        localparam logic [4:0] A_DHI = 5'(tpg_pkg::OFS_CH_BASE + c * tpg_pkg::OFS_CH_STRIDE + tpg_pkg::OFS_DHI);
        localparam logic [4:0] A_DLO = 5'(tpg_pkg::OFS_CH_BASE + c * tpg_pkg::OFS_CH_STRIDE + tpg_pkg::OFS_DLO);
        logic [1:0] sel;
        tpg_pkg::tpg_chcfg_type cfg;

        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                en_q[c] <= 1'b0;
                pol_q[c] <= 1'b0;
            end else if (i_wr && i_addr == A_CTRL) begin
                en_q[c] <= i_wdata[tpg_pkg::CTRL_EN_BIT];
                pol_q[c] <= i_wdata[tpg_pkg::CTRL_POL_BIT];
            end
        end

        // duty may be written at any time; only the buffer copy drives the compare
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                dhi_q[c] <= tpg_pkg::DHI_RST;
                dlo_q[c] <= tpg_pkg::DLO_RST;
            end else if (i_wr) begin
                if (i_addr == A_DHI) begin
                    dhi_q[c] <= i_wdata;
                end
                if (i_addr == A_DLO) begin
                    dlo_q[c] <= i_wdata[tpg_pkg::DLO_LSB +: 2];
                end
            end
        end

        // reserved code 00 falls back to the first timer rather than stalling
        assign sel = tsel_q[tpg_pkg::TSEL_CH_LSB + 2 * c +: 2];
        assign tidx[c] = (sel == tpg_pkg::TSEL_THIRD) ? 2'h2 :
                         (sel == tpg_pkg::TSEL_SECOND) ? 2'h1 : 2'h0;
        assign ch_tick[c] = tick[tidx[c]];

        assign cfg.en = en_q[c];
        assign cfg.polarity_select_bit = pol_q[c];
        assign cfg.duty = {dhi_q[c], dlo_q[c]};

        tpg_channel u_chan (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_run(!i_sleep),
            .i_tick(ch_tick[c]),
            .i_cfg(cfg),
            .o_out(out_lvl[c])
        );

        a_route_wrap: assert property (@(posedge i_clk) disable iff (!i_resetn)
            ch_tick[c].wrap == ((sel == 2'h3) ? tick[2].wrap : (sel == 2'h2) ? tick[1].wrap : tick[0].wrap))
            else $error("channel not routed to its selected timer");
    end

    // read side: data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            if (i_addr == tpg_pkg::OFS_TSEL) begin
                rdata_d = tsel_q;
            end
            if (i_addr == tpg_pkg::OFS_DIR) begin
                rdata_d[NC-1:0] = ~oe_q;
            end
            for (int c = 0; c < NC; c++) begin
                if (i_addr == 5'(tpg_pkg::OFS_CH_BASE + c * tpg_pkg::OFS_CH_STRIDE + tpg_pkg::OFS_CTRL)) begin
                    rdata_d[tpg_pkg::CTRL_EN_BIT] = en_q[c];
                    rdata_d[tpg_pkg::CTRL_OUT_BIT] = out_lvl[c];
                    rdata_d[tpg_pkg::CTRL_POL_BIT] = pol_q[c];
                end
                if (i_addr == 5'(tpg_pkg::OFS_CH_BASE + c * tpg_pkg::OFS_CH_STRIDE + tpg_pkg::OFS_DHI)) begin
                    rdata_d = dhi_q[c];
                end
                if (i_addr == 5'(tpg_pkg::OFS_CH_BASE + c * tpg_pkg::OFS_CH_STRIDE + tpg_pkg::OFS_DLO)) begin
                    rdata_d[tpg_pkg::DLO_LSB +: 2] = dlo_q[c];
                end
            end
            for (int t = 0; t < NT; t++) begin
                if (i_addr == 5'(tpg_pkg::OFS_TMR_BASE + t * tpg_pkg::OFS_TMR_STRIDE + tpg_pkg::OFS_TCNT)) begin
                    rdata_d = tcnt[t];
                end
                if (i_addr == 5'(tpg_pkg::OFS_TMR_BASE + t * tpg_pkg::OFS_TMR_STRIDE + tpg_pkg::OFS_TPER)) begin
                    rdata_d = tper_q[t];
                end
                if (i_addr == 5'(tpg_pkg::OFS_TMR_BASE + t * tpg_pkg::OFS_TMR_STRIDE + tpg_pkg::OFS_TCON)) begin
                    rdata_d[tpg_pkg::TCON_ON_BIT] = ton_q[t];
                    rdata_d[tpg_pkg::TCON_PS_LSB +: 2] = tps_q[t];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    sequence s_ctrl_read;
        i_rd && i_addr == 5'(tpg_pkg::OFS_CH_BASE + tpg_pkg::OFS_CTRL);
    endsequence

    a_out_readback: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_ctrl_read |=> o_rdata[tpg_pkg::CTRL_OUT_BIT] == $past(o_pwm[0]) && o_rdata[3:0] == 4'h0)
        else $error("control read does not show output level");
    a_read_once: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_dir_follow: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr && i_addr == tpg_pkg::OFS_DIR |=> o_pwm_oe == ~$past(i_wdata[NC-1:0]))
        else $error("pin direction not applied");
    a_sleep_pins: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_sleep ##1 i_sleep |-> $stable(o_pwm))
        else $error("pwm pins moved during sleep");
endmodule

// >>> testbench/tpg_pin_load.sv
// Purpose: external load on the two pwm pins, measures period and high time
// Assumes: a pin that is not driven is pulled down
// Notes: counts are in system clocks; the first period after reset is partial
module tpg_pin_load (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [1:0] i_drive,
    input wire logic [1:0] i_oe,
    output logic [1:0] o_pin,
    output logic [1:0][15:0] o_period,
    output logic [1:0][15:0] o_high,
    output logic [1:0][7:0] o_rises,
    output logic [1:0][7:0] o_falls
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] prev_q;
    logic [1:0][15:0] since_q;
    // a released pin sits at the pull-down level, never at the last driven value
    assign o_pin = i_drive & i_oe;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_q <= '0;
            since_q <= '0;
            o_period <= '0;
            o_high <= '0;
            o_rises <= '0;
            o_falls <= '0;
        end else begin
            prev_q <= o_pin;
            for (int c = 0; c < 2; c++) begin
                since_q[c] <= since_q[c] + 16'h0001;
                if (o_pin[c] && !prev_q[c]) begin
                    o_period[c] <= since_q[c];
                    since_q[c] <= 16'h0001;
                    o_rises[c] <= o_rises[c] + 8'h01;
                end
                if (!o_pin[c] && prev_q[c]) begin
                    o_high[c] <= since_q[c];
                    o_falls[c] <= o_falls[c] + 8'h01;
                end
            end
        end
    end
endmodule

// >>> testbench/tpg_pwm_tb_top.sv
// Purpose: self-checking bench of the two-channel pwm block
// Assumes: register port with one-cycle strobes, reads answered next cycle
// Notes: each random round resets the block so timers start from zero
module tpg_pwm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_resetn, i_sleep, i_wr, i_rd;
    logic [4:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic [1:0] o_pwm, o_pwm_oe, pin;
    logic [1:0][15:0] l_per, l_high;
    logic [1:0][7:0] l_rise, l_fall;
    logic [31:0] seed = 32'h0000005D;
    int bad_count = 0;
    int cmp_count = 0;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t mismatch got %0h exp %0h", $time, g, e); end end

    tpg_pwm_top tpg_pwm_top_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_sleep(i_sleep),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe));
    tpg_pin_load tpg_pin_load_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_drive(o_pwm),
        .i_oe(o_pwm_oe), .o_pin(pin), .o_period(l_per), .o_high(l_high), .o_rises(l_rise),
        .o_falls(l_fall));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] rst_val(input logic [4:0] a);
        case (a)
            5'h06: return 8'h55;
            5'h07: return 8'h03;
            5'h09, 5'h0D, 5'h11: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [15:0] exp_per(input logic [7:0] p, input logic [1:0] s);
        return 16'((int'(p) + 1) * 4 * (1 << (2 * int'(s))));
    endfunction

    function automatic logic [15:0] exp_high(input logic [9:0] d, input logic [1:0] s,
                                             input logic polarity_select_bit, input logic [15:0] per);
        int h;
        h = int'(d) * (1 << (2 * int'(s)));
        return polarity_select_bit ? per - 16'(h) : 16'(h);
    endfunction

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic do_reset();
        logic [7:0] d;
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        // count and output-level bits must ignore writes
        wr(5'h08, 8'hA5);
        wr(5'h00, 8'h20);
        for (int a = 0; a < 32; a++) begin
            rd(5'(a), d);
            `CHK(d, rst_val(5'(a)))
        end
        `CHK(o_pwm_oe, 2'h0)
    endtask

    task automatic run_iter(input int it);
        logic [7:0] per [3];
        logic [1:0] ps [3];
        logic [1:0] sel [2];
        logic polarity_select_bit [2];
        logic [9:0] duty [2];
        logic [15:0] p;
        logic [7:0] d;
        logic raw;
        int tm, full, guard;
        do_reset();
        for (int t = 0; t < 3; t++) begin
            ps[t] = 2'(rnd());
            per[t] = (ps[t] == 2'h3) ? 8'(rnd() & 3) : 8'(rnd() & 7);
            wr(5'(9 + 4 * t), per[t]);
            wr(5'(10 + 4 * t), {6'h00, ps[t]});
        end
        for (int c = 0; c < 2; c++) begin
            sel[c] = 2'(rnd());
            polarity_select_bit[c] = (it == 0) ? 1'b0 : 1'(rnd());
            tm = (sel[c] == 2'h0) ? 0 : int'(sel[c]) - 1;
            full = 4 * (int'(per[tm]) + 1);
            duty[c] = 10'(rnd() % 32'(full - 1) + 1);
            if (it == 0) duty[c] = (c == 1) ? 10'h3FF : 10'(full);
            if (it == 1) duty[c] = (c == 1) ? 10'(full - 1) : 10'h000;
            wr(5'(3 * c + 1), duty[c][9:2]);
            wr(5'(3 * c + 2), {duty[c][1:0], 6'h00});
            wr(5'(3 * c), {1'b1, 2'h0, polarity_select_bit[c], 4'h0});
        end
        wr(5'h06, {sel[1], sel[0], 4'h0});
        wr(5'h07, 8'h00);
        @(posedge i_clk);
        `CHK(o_pwm_oe, 2'h3)
        for (int t = 0; t < 3; t++) wr(5'(10 + 4 * t), {6'h20, ps[t]});
        for (int c = 0; c < 2; c++) begin
            tm = (sel[c] == 2'h0) ? 0 : int'(sel[c]) - 1;
            full = 4 * (int'(per[tm]) + 1);
            p = exp_per(per[tm], ps[tm]);
            if (duty[c] != 10'h000 && int'(duty[c]) < full) begin
                guard = 0;
                while (!(l_rise[c] >= 8'h03 && l_fall[c] >= 8'h02) && guard < 6 * int'(p)) begin
                    @(posedge i_clk);
                    guard++;
                end
                `CHK(l_per[c], p)
                `CHK(l_high[c], exp_high(duty[c], ps[tm], polarity_select_bit[c], p))
            end else begin
                raw = (duty[c] != 10'h000);
                repeat (2 * int'(p)) @(posedge i_clk);
                `CHK(pin[c], raw ^ polarity_select_bit[c])
                repeat (int'(p)) @(posedge i_clk);
                `CHK(pin[c], raw ^ polarity_select_bit[c])
                rd(5'(3 * c), d);
                `CHK(d, {1'b1, 1'b0, raw ^ polarity_select_bit[c], polarity_select_bit[c], 4'h0})
            end
        end
        for (int c = 0; c < 2; c++) begin
            wr(5'(3 * c), {3'h0, polarity_select_bit[c], 4'h0});
            tm = (sel[c] == 2'h0) ? 0 : int'(sel[c]) - 1;
            repeat (int'(exp_per(per[tm], ps[tm])) + 4) @(posedge i_clk);
            `CHK(o_pwm[c], polarity_select_bit[c])
        end
    endtask

    task automatic sleep_test();
        logic [7:0] c1, c2, c3;
        logic [1:0] hold;
        do_reset();
        wr(5'h01, 8'h10);
        wr(5'h00, 8'h80);
        wr(5'h07, 8'h00);
        wr(5'h0A, 8'h80);
        // first wrap lands at 1024 clocks, so the pin is high when sleep starts
        repeat (1040) @(posedge i_clk);
        i_sleep <= 1'b1;
        rd(5'h08, c1);
        hold = o_pwm;
        repeat (200) @(posedge i_clk);
        rd(5'h08, c2);
        `CHK(c2, c1)
        `CHK(o_pwm, hold)
        `CHK(hold, 2'h1)
        @(posedge i_clk);
        i_sleep <= 1'b0;
        repeat (40) @(posedge i_clk);
        rd(5'h08, c3);
        `CHK(8'(c3 - c1) inside {[8'h09:8'h0C]}, 1'b1)
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        #1000000;
        bad_count++;
        print_verdict();
    end

    initial begin
        i_resetn = 1'b0;
        i_sleep = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 5'h00;
        i_wdata = 8'h00;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int it = 0; it < 8; it++) run_iter(it);
        sleep_test();
        print_verdict();
    end
endmodule
